// *** hbus_pkg.sv ***
/*
 * package for the host-side controller of an SRAM-like Ethernet host port:
 * pin group and host command structs, timing figures and derived cycle counts.
 * assumes a single 100 MHz clock in the controller.
 */
package hbus_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int T_ASSERT_NS    = 32;
	localparam int T_DEASSERT_NS  = 13;
	localparam int T_CYCLE_NS     = 45;
	localparam int T_DATA_VALID_NS = 30;
	localparam int T_RST_PULSE_US = 200;
	localparam int T_CFG_SETUP_NS = 200;
	localparam int T_CFG_HOLD_NS  = 10;
	localparam int T_OUT_DRIVE_NS = 16;
	// least times round up
	localparam int ASSERT_CYC   = (T_ASSERT_NS * CLK_MHZ + 999) / 1000;
	localparam int DEASSERT_CYC = (T_DEASSERT_NS * CLK_MHZ + 999) / 1000;
	localparam int CYCLE_CYC    = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int DVALID_CYC   = (T_DATA_VALID_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_CYC      = T_RST_PULSE_US * CLK_MHZ;
	localparam int CFG_SU_CYC   = (T_CFG_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int CFG_HOLD_CYC = (T_CFG_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int DRIVE_CYC    = (T_OUT_DRIVE_NS * CLK_MHZ + 999) / 1000;

	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int HALF_W  = 16;
	localparam int FIFO_W  = 32;
	localparam int FIFO_D  = 16;
	localparam int CNT_W   = 16;
	localparam int RST_CNT_W = 20;

	// ------------------------------------------------------------
	// pin group toward the device
	// ------------------------------------------------------------
	typedef struct packed {
		logic              chip_select_low;
		logic              read_strobe_low;
		logic              write_strobe_low;
		logic              fifo_sel;
		logic [ADDR_W-1:0] addr;
		logic              reset_in_low;
	} pins_t;

	// host command from user logic
	typedef struct packed {
		logic              is_write;
		logic              wide;     // 1: 32-bit, 0: 16-bit
		logic              direct;   // drives fifo select
		logic              burst;    // keep strobes low to next read
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cmd_t;
endpackage

// *** hbus_fifo.sv ***
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and an already synchronised reset.
 */
`timescale 1ns/1ns
module hbus_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,     // clock
	input  wire logic             rst_n_in,   // synchronised reset
	input  wire logic             in_valid_in, // write request
	output logic                  in_ready_out, // not full
	input  wire logic [WIDTH-1:0] in_data_in, // write word
	output logic                  out_valid_out, // not empty
	input  wire logic             out_ready_in, // read accept
	output logic      [WIDTH-1:0] out_data_out // head word
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of two");
	end
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} st_t;
	st_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	// ------------------------------------------------------------
	// pointers
	// ------------------------------------------------------------
	assign in_ready_out  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid_out = (s_q.cnt != '0);
	assign out_data_out  = mem[s_q.rp];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	always_comb begin
		s_d = s_q;
		if (push) s_d.wp = s_q.wp + 1'b1;
		if (pop)  s_d.rp = s_q.rp + 1'b1;
		s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	// storage has no reset: contents are don't-care until written
	always_ff @(posedge clk_in) begin
		if (push) mem[s_q.wp] <= in_data_in;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) s_q <= '0;
		else s_q <= s_d;
	end
endmodule // hbus_fifo

// *** hbus_host.sv ***
/*
 * host controller driving the device's SRAM-like port: single and direct
 * fifo reads (with open-ended bursts), single writes, 16/32-bit widths and
 * the device reset sequence. read data is queued in a 16-word fifo.
 * assumes the device data pins are returned on dq_in; all pins async.
 */
`timescale 1ns/1ns
module hbus_host #(
	parameter int RST_CYCLES = hbus_pkg::RST_CYC
) (
	input  wire logic                        mclk_in,      // 100 MHz clock
	input  wire logic                        arst_n_in,    // async reset
	input  wire logic                        cmd_valid_in, // command request
	output logic                             cmd_ready_out, // command taken
	input  wire hbus_pkg::cmd_t              cmd_in,       // command fields
	output logic                             rd_valid_out, // read word ready
	input  wire logic                        rd_ready_in,  // read word taken
	output logic [hbus_pkg::DATA_W-1:0]      rd_data_out,  // read word
	output logic                             ready_out,    // device out of reset
	output hbus_pkg::pins_t                  pins_out,     // control pins
	input  wire logic [hbus_pkg::DATA_W-1:0] dq_in,        // data pins in
	output logic [hbus_pkg::DATA_W-1:0]      dq_out,       // data pins out
	output logic [1:0]                       dq_oe_n_out   // low half, high half enable
);
	initial begin
		// the reset counter must hold the whole pulse length
		if (RST_CYCLES < 1 || RST_CYCLES >= (1 << hbus_pkg::RST_CNT_W))
			$error("reset count out of range");
	end
	typedef enum logic [5:0] {
		S_RST  = 6'h01,
		S_WAKE = 6'h02,
		S_IDLE = 6'h04,
		S_ACT  = 6'h08,
		S_GAP  = 6'h10,
		S_HOLD = 6'h20
	} state_t;
	typedef struct packed {
		state_t                       st;
		logic [hbus_pkg::RST_CNT_W-1:0] rcnt;
		logic [hbus_pkg::CNT_W-1:0]   cnt;
		logic [hbus_pkg::CNT_W-1:0]   cyc;
		hbus_pkg::cmd_t               cmd;
		hbus_pkg::pins_t              pins;
		logic [1:0]                   oe_n;
		logic [hbus_pkg::DATA_W-1:0]  dq;
		logic                         ready;
	} st_t;
	st_t s_q, s_d;
	logic rs1_q, rs2_q;
	logic [hbus_pkg::DATA_W-1:0] dq1_q, dq2_q;
	logic push, fifo_rdy;
	logic [hbus_pkg::DATA_W-1:0] push_data;

	// ------------------------------------------------------------
	// reset release and data pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
			dq1_q <= '0;
			dq2_q <= '0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
			dq1_q <= dq_in;
			dq2_q <= dq1_q;
		end
	end

	// narrow reads keep only the low half
	function automatic logic [hbus_pkg::DATA_W-1:0] shape(input logic wide,
			input logic [hbus_pkg::DATA_W-1:0] d);
		shape = wide ? d : {{hbus_pkg::HALF_W{1'b0}}, d[hbus_pkg::HALF_W-1:0]};
	endfunction

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		push = 1'b0;
		push_data = shape(s_q.cmd.wide, dq2_q);
		cmd_ready_out = 1'b0;
		if (s_q.cyc != '0) s_d.cyc = s_q.cyc - 1'b1;
		if (s_q.cnt != '0) s_d.cnt = s_q.cnt - 1'b1;
		unique case (s_q.st)
			S_RST: begin
				s_d.pins.reset_in_low = 1'b0;
				if (s_q.rcnt == '0) begin
					s_d.pins.reset_in_low = 1'b1;
					s_d.cnt = hbus_pkg::CNT_W'(hbus_pkg::CFG_HOLD_CYC + hbus_pkg::DRIVE_CYC);
					s_d.st = S_WAKE;
				end else s_d.rcnt = s_q.rcnt - 1'b1;
			end
			S_WAKE: if (s_q.cnt == '0) begin
				s_d.ready = 1'b1;
				s_d.st = S_IDLE;
			end
			S_IDLE, S_HOLD: begin
				// hold keeps strobes low awaiting the next burst read
				if (cmd_valid_in && fifo_rdy && s_q.cyc == '0 &&
						(s_q.st == S_IDLE || (!cmd_in.is_write && cmd_in.direct &&
						cmd_in.burst))) begin
					cmd_ready_out = 1'b1;
					s_d.cmd = cmd_in;
					s_d.pins.addr = cmd_in.addr;
					s_d.pins.fifo_sel = cmd_in.direct;
					s_d.pins.chip_select_low = 1'b0;
					s_d.pins.read_strobe_low = cmd_in.is_write;
					s_d.pins.write_strobe_low = !cmd_in.is_write;
					s_d.dq = cmd_in.wdata;
					s_d.oe_n = cmd_in.is_write ? {!cmd_in.wide, 1'b0} : 2'b11;
					s_d.cnt = hbus_pkg::CNT_W'(hbus_pkg::ASSERT_CYC);
					s_d.cyc = hbus_pkg::CNT_W'(hbus_pkg::CYCLE_CYC);
					s_d.st = S_ACT;
				end else if (s_q.st == S_HOLD) begin
					// anything but a continuing burst read ends the burst: a queued
					// write or single read is served from idle after the gap
					s_d.pins.chip_select_low = 1'b1;
					s_d.pins.read_strobe_low = 1'b1;
					s_d.cnt = hbus_pkg::CNT_W'(hbus_pkg::DEASSERT_CYC);
					s_d.st = S_GAP;
				end
			end
			S_ACT: if (s_q.cnt == '0) begin
				if (!s_q.cmd.is_write) begin
					push = 1'b1;
				end
				if (!s_q.cmd.is_write && s_q.cmd.direct && s_q.cmd.burst) begin
					s_d.st = S_HOLD;
				end else begin
					s_d.pins.chip_select_low = 1'b1;
					s_d.pins.read_strobe_low = 1'b1;
					s_d.pins.write_strobe_low = 1'b1;
					s_d.oe_n = 2'b11;
					s_d.cnt = hbus_pkg::CNT_W'(hbus_pkg::DEASSERT_CYC);
					s_d.st = S_GAP;
				end
			end
			S_GAP: if (s_q.cnt == '0) s_d.st = S_IDLE;
			default: s_d.st = S_RST;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rs2_q) begin
		if (!rs2_q) begin
			s_q <= '{st: S_RST, rcnt: hbus_pkg::RST_CNT_W'(RST_CYCLES),
				cnt: '0, cyc: '0, cmd: '0,
				pins: '{chip_select_low: 1'b1, read_strobe_low: 1'b1,
				write_strobe_low: 1'b1, fifo_sel: 1'b0, addr: '0, reset_in_low: 1'b0},
				oe_n: 2'b11, dq: '0, ready: 1'b0};
		end else s_q <= s_d;
	end

	assign pins_out = s_q.pins;
	assign dq_out = s_q.dq;
	assign dq_oe_n_out = s_q.oe_n;
	assign ready_out = s_q.ready;

	// ------------------------------------------------------------
	// read data queue
	// ------------------------------------------------------------
	hbus_fifo #(.WIDTH(hbus_pkg::FIFO_W), .DEPTH(hbus_pkg::FIFO_D)) u_fifo (
		.clk_in(mclk_in),
		.rst_n_in(rs2_q),
		.in_valid_in(push),
		.in_ready_out(fifo_rdy),
		.in_data_in(push_data),
		.out_valid_out(rd_valid_out),
		.out_ready_in(rd_ready_in),
		.out_data_out(rd_data_out)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_ASSERT_MIN: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		$fell(s_q.pins.chip_select_low) |-> !s_q.pins.chip_select_low [*4])
		else $error("strobe assertion too short");
	AST_GAP_MIN: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		$rose(s_q.pins.chip_select_low) |-> s_q.pins.chip_select_low [*2])
		else $error("strobe gap too short");
	AST_NARROW_WR: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(!s_q.pins.write_strobe_low && !s_q.cmd.wide) |-> s_q.oe_n == 2'b10)
		else $error("upper half driven on narrow write");
	AST_READ_NODRV: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		!s_q.pins.read_strobe_low |-> s_q.oe_n == 2'b11)
		else $error("host drives bus during read");
	AST_ONE_STROBE: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		!(!s_q.pins.read_strobe_low && !s_q.pins.write_strobe_low))
		else $error("both strobes low");
	AST_PUSH_ONE: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		push |=> !push)
		else $error("two words from one cycle");
	AST_SEL_STABLE: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(s_q.st == S_ACT && $past(s_q.st) == S_ACT) |-> $stable(s_q.pins.fifo_sel))
		else $error("select moved mid cycle");
	AST_RST_HELD: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(s_q.st == S_RST) |-> !s_q.pins.reset_in_low)
		else $error("device reset released early");

	// ------------------------------------------------------------
	// checks on bursts, data and the read queue
	// ------------------------------------------------------------
	// a burst that is not continued must close at once
	AST_BURST_END: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(s_q.st == S_HOLD && !cmd_ready_out) |=> s_q.pins.chip_select_low)
		else $error("burst left open");
	// address may only move between accesses or at a burst step
	AST_ADDR_STABLE: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(s_q.st == S_ACT && $past(s_q.st) == S_ACT) |-> $stable(s_q.pins.addr))
		else $error("address moved mid cycle");
	// write data must stand for the whole strobe
	AST_WR_DATA: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(!s_q.pins.write_strobe_low && !$past(s_q.pins.write_strobe_low))
		|-> $stable(s_q.dq))
		else $error("write data moved mid cycle");
	// ready only once the device pin is released
	AST_READY_RST: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		ready_out |-> s_q.pins.reset_in_low)
		else $error("ready while device held in reset");
	// a word must never be pushed into a full queue
	AST_NO_OVERFLOW: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		push |-> fifo_rdy)
		else $error("read word pushed into full queue");
	// narrow reads carry nothing in the upper half
	AST_RD_SHAPE: assert property (@(posedge mclk_in) disable iff (!rs2_q)
		(push && !s_q.cmd.wide) |-> push_data[hbus_pkg::DATA_W-1:hbus_pkg::HALF_W] == '0)
		else $error("upper half kept on narrow read");
endmodule // hbus_host

// *** hbus_dev_model.sv ***
/*
 * behavioural model of the device port: register reads, rx fifo reads,
 * single writes logged for the bench.
 * assumes the bench resolves the data bus from the host's enables.
 */
`timescale 1ns/1ns
module hbus_dev_model (
	input  wire hbus_pkg::pins_t pins_in, // host control pins
	input  wire logic [31:0]     bus_in,  // resolved data bus
	output logic      [31:0]     dq_out   // device drive, junk when idle
);
	// ----------------------------------------
	// cycle detection
	// ----------------------------------------
	logic [40:0] log_q[$];
	logic [40:0] wlat;
	logic        rd_q, wr_q;
	logic [7:0]  a_q;
	int          rx_n;
	logic        rd_now, wr_now;
	// strobes only count once the device is out of reset
	wire wr_act = !pins_in.chip_select_low && !pins_in.write_strobe_low
		&& pins_in.reset_in_low;
	initial begin
		rx_n = 0;
		rd_q = 1'b0;
		wr_q = 1'b0;
		a_q = 8'h00;
		dq_out = 32'h5A5A_A5A5;
	end
	// new word on cycle start or address step within a burst
	// levels worked out here, so a not yet updated wire is never read
	always @(pins_in) begin
		rd_now = !pins_in.chip_select_low && !pins_in.read_strobe_low
			&& pins_in.reset_in_low;
		wr_now = !pins_in.chip_select_low && !pins_in.write_strobe_low
			&& pins_in.reset_in_low;
		if (rd_now && (!rd_q || pins_in.addr != a_q)) begin
			if (pins_in.fifo_sel) begin
				dq_out = 32'hC0DE_0000 | rx_n;
				rx_n++;
			end else begin
				dq_out = {24'hE1_0000, pins_in.addr};
			end
		end else if (!rd_now && rd_q) begin
			dq_out = ~dq_out; // released: no stale value
		end
		if (wr_q && !wr_now) begin
			log_q.push_back(wlat);
		end
		rd_q = rd_now;
		wr_q = wr_now;
		a_q = pins_in.addr;
	end
	// latch mid-cycle, clear of the end-of-cycle update race
	always begin
		@(posedge wr_act);
		#25;
		wlat = {pins_in.fifo_sel, pins_in.fifo_sel ? {5'h00, pins_in.addr[2:1], 1'b0}
			: pins_in.addr, bus_in};
	end
endmodule // hbus_dev_model

// *** test_hbus_host.sv ***
/*
 * self-checking bench for the host controller against the device model.
 * assumes the package and design files are compiled first.
 */
`timescale 1ns/1ns
module test_hbus_host;
	localparam int RSTC = 50;
	logic            mclk_in, arst_n_in, cmd_valid_in, rd_ready_in, stall;
	logic            cmd_ready_out, rd_valid_out, ready_out;
	hbus_pkg::cmd_t  cmd_in;
	hbus_pkg::pins_t pins_out;
	logic [31:0]     rd_data_out, dq_in, dq_out, dev_dq;
	logic [1:0]      dq_oe_n_out;
	logic [31:0]     exp_rd[$];
	logic [40:0]     exp_wr[$], exp_m[$];
	int              err_count, tests_run, seed, cyc, rx_exp, i, waited;
	// ----------------------------------------
	// wiring
	// ----------------------------------------
	// undriven halves show whatever the device leaves there
	assign dq_in = {dq_oe_n_out[1] ? dev_dq[31:16] : dq_out[31:16],
		dq_oe_n_out[0] ? dev_dq[15:0] : dq_out[15:0]};
	hbus_host #(.RST_CYCLES(RSTC)) i_hbus_host (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_in(cmd_in),
		.rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out),
		.ready_out(ready_out), .pins_out(pins_out), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_n_out(dq_oe_n_out));
	hbus_dev_model i_hbus_dev_model (.pins_in(pins_out), .bus_in(dq_in), .dq_out(dev_dq));
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// ----------------------------------------
	// compare tasks
	// ----------------------------------------
	task note(input bit ok, input string what);
		tests_run++;
		if (!ok) begin
			err_count++;
			$display("Error at %0t: %s mismatch", $time, what);
		end
	endtask
	task chk_rd(input logic [31:0] g, e);
		note(g === e, "read word");
	endtask
	task chk_wr(input logic [40:0] g, e);
		note(g === e, "write log");
	endtask
	task chk_bit(input logic g, e);
		note(g === e, "flag");
	endtask
	task results;
		$display("tests %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one command with its expectation; valid stays up for chaining
	task send(input logic w, wd, dr, bu, input logic [7:0] a, input logic [31:0] d);
		cmd_in <= {w, wd, dr, bu, a, d};
		cmd_valid_in <= 1'b1;
		if (w) begin
			exp_wr.push_back({dr, dr ? {5'h00, a[2:1], 1'b0} : a, d});
			exp_m.push_back({9'h1FF, wd ? 32'hFFFF_FFFF : 32'h0000_FFFF});
		end else if (dr) begin
			exp_rd.push_back(wd ? 32'hC0DE_0000 | rx_exp : {16'h0000, 16'(rx_exp)});
			rx_exp++;
		end else
			exp_rd.push_back(wd ? {24'hE1_0000, a} : {24'h00_0000, a});
		for (waited = 0; waited < 300; waited++) begin
			@(negedge mclk_in);
			if (cmd_ready_out === 1'b1) break;
		end
		note(waited < 300, "command take");
		@(posedge mclk_in);
	endtask
	// ----------------------------------------
	// read side sink and watchdog
	// ----------------------------------------
	always @(posedge mclk_in) begin
		rd_ready_in <= !stall && (($random(seed) & 1) != 0);
		if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
			chk_rd(rd_data_out, exp_rd.pop_front());
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h01ea;
		{err_count, tests_run, cyc, rx_exp} = '0;
		{arst_n_in, cmd_valid_in, stall, rd_ready_in} = '0;
		cmd_in = '0;
		repeat (6) @(posedge mclk_in);
		chk_bit(pins_out.reset_in_low, 1'b0);
		chk_bit(pins_out.chip_select_low, 1'b1);
		arst_n_in <= 1'b1;
		for (i = 0; i < RSTC + 30 && ready_out !== 1'b1; i++) @(posedge mclk_in);
		chk_bit(ready_out, 1'b1);
		chk_bit(pins_out.reset_in_low, 1'b1);
		chk_bit(i >= RSTC, 1'b1);
		for (i = 0; i < 10; i++)
			send(1'b1, i[0], i[1], 1'b0, 8'($random(seed)), $random(seed));
		for (i = 0; i < 8; i++)
			send(1'b0, i[0], i[1], 1'b0, 8'($random(seed)), 32'h0);
		for (i = 0; i < 6; i++)
			send(1'b0, 1'b1, 1'b1, i < 5, 8'(8'h40 + 2 * i), 32'h0);
		cmd_valid_in <= 1'b0;
		for (i = 0; i < 500 && exp_rd.size() > 0; i++) @(posedge mclk_in);
		// stalled sink: buffer fills and the 17th command is refused
		stall <= 1'b1;
		fork
			begin
				repeat (200) @(posedge mclk_in);
				stall <= 1'b0;
			end
		join_none
		for (i = 0; i < 17; i++)
			send(1'b0, 1'b1, 1'b1, 1'b0, 8'(4 * i), 32'h0);
		chk_bit(waited > 20, 1'b1);
		cmd_valid_in <= 1'b0;
		for (i = 0; i < 600 && exp_rd.size() > 0; i++) @(posedge mclk_in);
		repeat (10) @(posedge mclk_in);
		chk_bit(i_hbus_dev_model.log_q.size() == exp_wr.size(), 1'b1);
		for (i = 0; i < exp_wr.size(); i++)
			chk_wr(i_hbus_dev_model.log_q[i] & exp_m[i], exp_wr[i] & exp_m[i]);
		chk_bit(i_hbus_dev_model.rx_n == rx_exp, 1'b1);
		chk_bit(exp_rd.size() == 0, 1'b1);
		results();
	end
endmodule // test_hbus_host
